// >>> hdl/power_stage_host.sv
// host controller that drives a two-channel class-d power stage through its pins
//
// Contract
// R1: enable low floats that channel's output
// R2: enable and reference on pass switch input
// R3: release output echoes switch input, delayed
// R4: hold reference on while stage operates
// R5: fault report low above upper temperature
// R6: report released at lower temperature, hysteresis
// R7: fault report low on channel overcurrent
// R8: fault report is open drain, low only
// R9: controller shuts system down on fault
// R10: fast shutdown, then fixed recovery wait
// R11: current limit defaults to full value
// R12: bridged mono drives channels opposite phase
// R13: fault report ors all fault sources
`timescale 1ns/100ps
`include "power_stage_host_defs.svh"

module power_stage_host
  import power_stage_host_pkg::*;
#(
  parameter int unsigned RECOVERY_CYCLES = `RECOVERY_CYCLES,
  parameter int unsigned SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES,
  parameter int unsigned SETTLE_CYCLES   = `SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // user side: system control and modulator streams
  input  wire logic systemOn,
  input  wire logic bridgedMonoMode,
  input  wire logic pwmCh1,
  input  wire logic pwmCh2,
  output logic      running,
  output logic      faultSeen,
  output logic      releaseMismatch,
  // power stage side: drive pins
  output logic      switchInCh1,
  output logic      switchInCh2,
  output logic      chanEnableCh1,
  output logic      chanEnableCh2,
  output logic      referenceOnIn,
  // power stage side: echo and diagnostic pins
  input  wire logic releaseOutCh1,
  input  wire logic releaseOutCh2,
  input  wire logic faultReport_n
);

  localparam int CW = 25;  // counter wide enough for the recovery wait

  // timing summary, in ref_clk edges:
  //   systemOn seen in off        -> reference on at the next edge
  //   settle count reaches limit  -> enables and switches follow
  //   fault pin low               -> two sync edges, then all drive pins low
  //   recovery wait               -> RECOVERY_CYCLES edges before a retry
  // SHUTDOWN_CYCLES is only a budget; from settle or run the sequencer
  // drops the outputs one edge after the synced fault is seen

  // synchronised pins
  logic [2:0]    pinsSync;        // {fault_n, release_out_ch2, release_out_ch1}
  logic          faultActive;     // diagnostic pulled low
  logic          relCh1;          // synced release ch1
  logic          relCh2;          // synced release ch2
  // sequencer
  seq_state_type state;           // current state
  seq_state_type next_state;      // next state
  logic [CW-1:0] count;           // state timer
  logic [CW-1:0] next_count;      // next timer value
  // switch history to compare echoes against
  logic [3:0]    sw1Hist;         // past switch levels ch1
  logic [3:0]    sw2Hist;         // past switch levels ch2
  // next output values
  logic          next_sw1;        // next switch ch1
  logic          next_sw2;        // next switch ch2
  logic          next_enable;     // channels enabled
  logic          next_refOn;      // reference on
  logic          echoBad;         // echo disagrees with all recent switch levels

  // release and diagnostic pins are asynchronous to ref_clk
  pin_sync #(
    .WIDTH      (3)
  ) u_sync (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .pinIn      ({faultReport_n, releaseOutCh2, releaseOutCh1}),
    .resetValue (3'h7),
    .pinSync    (pinsSync)
  );

  // fault is low-active; one or-ed source, no cause given [R8] [R13]
  assign faultActive = ~pinsSync[2];
  assign relCh1      = pinsSync[0];
  assign relCh2      = pinsSync[1];

  // the sequencer walks off -> settle -> run, and on a fault
  // run -> shutdown -> recover -> settle (or off if no longer wanted);
  // systemOn is ignored until the recovery wait has run out
  // sequencer next state and timer
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      // everything off until requested
      ST_OFF: begin
        next_count = '0;
        if (systemOn) begin
          next_state = ST_SETTLE;
        end
      end
      // references on, let them settle before enabling channels
      ST_SETTLE: begin
        next_count = count + 1'b1;
        if (!systemOn) begin
          next_state = ST_OFF;
        end else if (faultActive) begin
          next_state = ST_SHUTDOWN;
          next_count = '0;
        end else if (count >= CW'(SETTLE_CYCLES - 1)) begin
          next_state = ST_RUN;
        end
      end
      // normal operation; fault forces shutdown [R9]
      ST_RUN: begin
        next_count = '0;
        if (faultActive) begin
          next_state = ST_SHUTDOWN;
        end else if (!systemOn) begin
          next_state = ST_OFF;
        end
      end
      // outputs already off; one cycle, well within the shutdown time [R10]
      ST_SHUTDOWN: begin
        next_count = '0;
        next_state = ST_RECOVER;
      end
      // fixed recovery wait before a restart attempt [R10]
      ST_RECOVER: begin
        next_count = count + 1'b1;
        if (count >= CW'(RECOVERY_CYCLES - 1)) begin
          next_count = '0;
          next_state = systemOn ? ST_SETTLE : ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
        next_count = '0;
      end
    endcase
  end

  // reference held on continuously while operating [R4]
  assign next_refOn  = (next_state == ST_SETTLE) || (next_state == ST_RUN);
  // channels enabled only in run; disabled floats the outputs [R1] [R2]
  assign next_enable = (next_state == ST_RUN);
  // bridged mono: channel 2 is channel 1 inverted [R12]
  assign next_sw1    = next_enable & pwmCh1;
  assign next_sw2    = next_enable & (bridgedMonoMode ? ~pwmCh1 : pwmCh2);

  // only checked in run; in settle the synchroniser may still hold its
  // reset level, which would give a false mismatch
  // release echo must match some switch level of the recent past [R3]
  assign echoBad = (state == ST_RUN) &&
                   ((relCh1 ? ~|sw1Hist : &sw1Hist) ||
                    (relCh2 ? ~|sw2Hist : &sw2Hist));

  // state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OFF;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // every drive pin comes straight from a flop, so no decode glitch
  // reaches the stage; enables and reference drop on the same edge
  // pin drive registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      referenceOnIn <= `RESET_REF_ON;
      chanEnableCh1 <= `RESET_ENABLE;
      chanEnableCh2 <= `RESET_ENABLE;
      switchInCh1   <= `RESET_SWITCH;
      switchInCh2   <= `RESET_SWITCH;
    end else begin
      referenceOnIn <= next_refOn;
      chanEnableCh1 <= next_enable;
      chanEnableCh2 <= next_enable;
      switchInCh1   <= next_sw1;
      switchInCh2   <= next_sw2;
    end
  end

  // the release pins come back through the two-flop synchroniser, so a
  // release level lags its switch level by two to three edges; four
  // entries of history cover that lag with one edge of margin
  // history of driven switch levels
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw1Hist <= 4'h0;
      sw2Hist <= 4'h0;
    end else begin
      sw1Hist <= {sw1Hist[2:0], switchInCh1};
      sw2Hist <= {sw2Hist[2:0], switchInCh2};
    end
  end

  // faultSeen is not latched: it follows the synced pin, so the user
  // sees the fault for as long as the stage reports it
  // user status flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      running         <= 1'b0;
      faultSeen       <= 1'b0;
      releaseMismatch <= 1'b0;
    end else begin
      running         <= (next_state == ST_RUN);
      faultSeen       <= faultActive;
      releaseMismatch <= echoBad;
    end
  end

endmodule : power_stage_host

// >>> hdl/power_stage_host_defs.svh
// timing constants and reset values of the power stage host
`ifndef POWER_STAGE_HOST_DEFS_SVH
`define POWER_STAGE_HOST_DEFS_SVH

// shutdown reaction time after a fault report, ns
`define SHUTDOWN_TIME_NS      1000
// recovery wait before a restart attempt, ms
`define RECOVERY_TIME_MS      220
// clock period, ns
`define CLOCK_PERIOD_NS       10
// longest shutdown time rounds down to whole cycles
`define SHUTDOWN_CYCLES       (`SHUTDOWN_TIME_NS / `CLOCK_PERIOD_NS)
// least recovery time rounds up to whole cycles
`define RECOVERY_CYCLES       ((`RECOVERY_TIME_MS * 1000000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
// settle time from reference-on to channel enable, cycles
`define SETTLE_CYCLES         16
// reset values of the drive pins
`define RESET_REF_ON          1'b0
`define RESET_ENABLE          1'b0
`define RESET_SWITCH          1'b0

`endif

// >>> hdl/power_stage_host_pkg.sv
// types of the power stage host
package power_stage_host_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SETTLE,
    ST_RUN,
    ST_SHUTDOWN,
    ST_RECOVER
  } seq_state_type;

endpackage : power_stage_host_pkg

// >>> hdl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // asynchronous pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] resetValue,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stageOne;  // first stage, read only by second

  // one pair of flops per pin
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          stageOne[i] <= 1'b1;
          pinSync[i]  <= 1'b1;
        end else begin
          stageOne[i] <= pinIn[i];
          pinSync[i]  <= stageOne[i];
        end
      end
    end
  endgenerate

  // reset value port kept for callers; idle level of all pins here is high
  logic unusedReset;
  assign unusedReset = ^resetValue;

endmodule : pin_sync

// >>> test/power_stage_host_chk.sv
// assertions on the host ports
`timescale 1ns/100ps
module power_stage_host_chk #(
  parameter int unsigned RECOVERY_CYCLES = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // user side
  input wire logic systemOn,
  input wire logic bridgedMonoMode,
  input wire logic pwmCh1,
  input wire logic pwmCh2,
  input wire logic running,
  input wire logic faultSeen,
  input wire logic releaseMismatch,
  // drive pins
  input wire logic switchInCh1,
  input wire logic switchInCh2,
  input wire logic chanEnableCh1,
  input wire logic chanEnableCh2,
  input wire logic referenceOnIn,
  // echo and diagnostic pins
  input wire logic releaseOutCh1,
  input wire logic releaseOutCh2,
  input wire logic faultReport_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rec;      // a fault shutdown happened
  logic refLast;  // reference level at the last edge
  int   cnt;      // cycles since that shutdown
  // count from the fault drop of the reference
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rec     <= 1'b0;
      refLast <= 1'b0;
      cnt     <= 0;
    end else begin
      refLast <= referenceOnIn;
      if (refLast && !referenceOnIn && faultSeen) begin
        rec <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // new fault held for three samples
  sequence s_fault;
    $fell(faultReport_n) ##1 !faultReport_n [*2];
  endsequence
  property p_ref;
    chanEnableCh1 || chanEnableCh2 |-> referenceOnIn;
  endproperty
  a_ref: assert property (p_ref) else $error("enable without reference");
  property p_stop;
    s_fault |=> !chanEnableCh1 && !chanEnableCh2 && !referenceOnIn;
  endproperty
  a_stop: assert property (p_stop) else $error("no shutdown on fault");
  property p_wait;
    $rose(referenceOnIn) && rec |-> cnt >= RECOVERY_CYCLES;
  endproperty
  a_wait: assert property (p_wait) else $error("restart too early");
  property p_btl;
    $past(chanEnableCh2) && chanEnableCh2 && $past(bridgedMonoMode)
      |-> switchInCh2 != $past(pwmCh1);
  endproperty
  a_btl: assert property (p_btl) else $error("channel 2 not inverted");
endmodule : power_stage_host_chk

bind power_stage_host power_stage_host_chk #(.RECOVERY_CYCLES(RECOVERY_CYCLES))
  power_stage_host_chk_i (.*);

// >>> test/power_stage_model.sv
// behavioural model of the two-channel power stage
`timescale 1ns/100ps
module power_stage_model #(
  parameter int LIMIT = 75  // current limit, 0.1 A, limit input at negative supply
) (
  // drive pins from the host
  input  wire logic switchInCh1,
  input  wire logic switchInCh2,
  input  wire logic chanEnableCh1,
  input  wire logic chanEnableCh2,
  input  wire logic referenceOnIn,
  // junction temperature in C, load currents in 0.1 A
  input  var  int   tempC,
  input  var  int   ampCh1,
  input  var  int   ampCh2,
  // pins to host and load
  output wire logic releaseOutCh1,
  output wire logic releaseOutCh2,
  output wire logic powerOutCh1,
  output wire logic powerOutCh2,
  output wire logic faultReport_n
);
  logic hot = 1'b0;  // thermal fault with hysteresis
  // set above upper, clear at lower threshold
  always @(tempC) begin
    if (tempC > 150) hot = 1'b1;
    else if (tempC <= 130) hot = 1'b0;
  end
  // one shared report, pulled low only
  assign faultReport_n = (hot || ampCh1 > LIMIT || ampCh2 > LIMIT) ?
                         1'b0 : 1'bz;
  assign #3 releaseOutCh1 = switchInCh1;
  assign #3 releaseOutCh2 = switchInCh2;
  // float unless enabled and referenced
  assign powerOutCh1 = chanEnableCh1 && referenceOnIn ? switchInCh1 : 1'bz;
  assign powerOutCh2 = chanEnableCh2 && referenceOnIn ? switchInCh2 : 1'bz;
endmodule : power_stage_model

// >>> test/class_d_power_stage_control_bench.sv
// bench of the power stage host with a stage model
`timescale 1ns/100ps
module class_d_power_stage_control_bench;
  localparam int REC = 50;  // short recovery wait
  localparam int SET = 4;   // short settle time
  logic ref_clk = 1'b0, rst_b = 1'b0, systemOn = 1'b0, bridgedMonoMode = 1'b0;
  logic pwmCh1 = 1'b0, pwmCh2 = 1'b0, running, faultSeen, releaseMismatch;
  logic switchInCh1, switchInCh2, chanEnableCh1, chanEnableCh2, referenceOnIn;
  wire  releaseOutCh1, releaseOutCh2, powerOutCh1, powerOutCh2;
  tri1  faultReport_n;  // open-drain line, pulled up
  int   tempC = 25, ampCh1 = 0, ampCh2 = 0, errCount = 0, comparisons = 0;
  power_stage_host #(.RECOVERY_CYCLES(REC), .SETTLE_CYCLES(SET)) power_stage_host_i (.*);
  power_stage_model power_stage_model_i (.*);
  // free-running clock
  initial forever #5 ref_clk = ~ref_clk;
  // wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endOfTest
  task automatic testStart;
    systemOn = 1'b1;
    cyc(2);
    chk("ref", 1'b1, referenceOnIn);
    chk("early enable", 1'b0, chanEnableCh1);
    cyc(SET + 2);
    chk("running", 1'b1, running);
    pwmCh1 = 1'b1;
    cyc(3);
    chk("power_out_ch1", 1'b1, powerOutCh1);
    chk("power_out_ch2", 1'b0, powerOutCh2);
    chk("echo", 1'b0, releaseMismatch);
    $display("start done");
  endtask : testStart
  task automatic testBridge;
    bridgedMonoMode = 1'b1;
    pwmCh2 = 1'b1;
    cyc(3);
    chk("btl power_out_ch2", 1'b0, powerOutCh2);
    pwmCh1 = 1'b0;
    cyc(3);
    chk("btl power_out_ch2", 1'b1, powerOutCh2);
    $display("bridge done");
  endtask : testBridge
  task automatic testHeat;
    tempC = 151;
    cyc(4);
    chk("hot", 1'b1, faultSeen);
    chk("stop", 1'b0, chanEnableCh1);
    chk("float", 1'bz, powerOutCh1);
    tempC = 131;
    cyc(4);
    chk("held", 1'b1, faultSeen);
    tempC = 130;
    cyc(4);
    chk("cool", 1'b0, faultSeen);
    cyc(REC - 9);
    chk("waiting", 1'b0, referenceOnIn);
    cyc(1);
    chk("retry", 1'b1, referenceOnIn);
    cyc(SET);
    chk("restart", 1'b1, running);
    $display("heat done");
  endtask : testHeat
  task automatic testShort;
    ampCh1 = 75;
    cyc(4);
    chk("at limit", 1'b0, faultSeen);
    ampCh2 = 76;
    cyc(4);
    chk("short", 1'b0, running);
    ampCh1 = 0;
    ampCh2 = 0;
    cyc(REC + SET + 10);
    chk("restart", 1'b1, running);
    systemOn = 1'b0;
    cyc(3);
    chk("off", 1'b0, referenceOnIn);
    $display("short done");
  endtask : testShort
  // main sequence
  initial begin
    cyc(3);
    rst_b = 1'b1;
    testStart();
    testBridge();
    testHeat();
    testShort();
    endOfTest();
  end
  // watchdog
  initial begin
    #20000;
    errCount++;
    endOfTest();
  end
endmodule : class_d_power_stage_control_bench
